// ---- include/lbe_pkg.sv ----
// constants, types and register map of the limit-test binning engine
package lbe_pkg;

	// number of two-sided limit tests (tests 2, 3, 5..12)
	localparam int NLIM = 10;
	localparam int FAIL_W = 13;

	// register byte offsets on the AXI4-Lite slave
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CMD = 8'h04;
	localparam logic [7:0] OFS_NULL = 8'h08;
	localparam logic [7:0] OFS_PATS = 8'h0C;
	localparam logic [7:0] OFS_FAIL = 8'h10;
	localparam logic [7:0] OFS_LATEST = 8'h14;
	localparam logic [7:0] OFS_STAT = 8'h18;
	localparam logic [7:0] OFS_LIM_BASE = 8'h40;
	localparam logic [7:0] OFS_LIM_END = 8'hE0;

	// word within a limit's 16-byte slot
	localparam logic [1:0] LSUB_LOWER = 2'h0;
	localparam logic [1:0] LSUB_UPPER = 2'h1;
	localparam logic [1:0] LSUB_PATS = 2'h2;

	// command register bits, write-one pulses
	localparam int CMD_ACQ = 0;
	localparam int CMD_CLR = 1;

	// fail flag bit positions for the fixed tests
	localparam int FBIT_COMPL = 1;
	localparam int FBIT_CONTACT = 4;

	// bound and offset range, symmetric signed
	localparam logic signed [31:0] VAL_MAX = 32'sh7FFF_FFFF;
	localparam logic signed [31:0] VAL_MIN = 32'sh8000_0001;
	localparam logic [31:0] VAL_FORBID = 32'h8000_0000;
	localparam logic [31:0] LOWER_DEF = 32'hFFFF_FFFF;
	localparam logic [31:0] UPPER_DEF = 32'h0000_0001;

	localparam logic [3:0] PAT3_MASK = 4'h7;
	localparam logic [3:0] PAT4_MASK = 4'hF;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {FEED_MATH, FEED_VOLT, FEED_CURR, FEED_RES} lbe_feed_t;

	// control word, feed sits in the low bits
	typedef struct packed {
		logic [NLIM-1:0] limx_en;
		logic lim1_en;
		logic contact_en;
		logic compl_fail_out;
		logic end_update;
		logic four_bit;
		logic sorting;
		logic null_en;
		lbe_feed_t feed;
	} lbe_ctrl_t;

	typedef struct packed {
		logic [3:0] ordinary_pat;
		logic [3:0] composite_fail_pat;
		logic [3:0] composite_pass_pat;
		logic [3:0] contact_fail_pat;
		logic [3:0] compl_fail_pat;
	} lbe_pats_t;

	typedef struct packed {
		logic [3:0] pass_pat;
		logic [3:0] upper_pat;
		logic [3:0] lower_pat;
	} lbe_lim_pats_t;

	typedef struct packed {
		logic acq_pending;
		logic have_reading;
		logic binned;
		logic [3:0] lines;
	} lbe_stat_t;

	// one reading set, all in signed units of the selected function
	typedef struct packed {
		logic signed [31:0] math;
		logic signed [31:0] volt;
		logic signed [31:0] curr;
		logic signed [31:0] res;
	} lbe_reading_t;

	localparam lbe_ctrl_t CTRL_RST = '0;
	localparam lbe_pats_t PATS_RST = '0;
	localparam lbe_lim_pats_t LPATS_RST = '0;

endpackage

// ---- rtl/lbe_limit_stage.sv ----
// limit-test binning engine: feed select, null offset, ordered tests, handler pattern
//
// Decided for this implementation: the register offsets and the AXI4-Lite register port.
`timescale 1ns/10ps

module lbe_limit_stage
	import lbe_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire lbe_reading_t reading,
	input wire logic reading_valid,
	input wire logic in_compliance,
	input wire logic contact_fail,
	input wire logic sweep_done,
	output logic [3:0] dout_lines
);

	// byte-lane merge for read-write words
	function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
			input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[8*b +: 8] = new_v[8*b +: 8];
			end
		end
		return r;
	endfunction

	// the single most-negative code is kept out so the range stays symmetric
	function automatic logic [31:0] clamp_val(input logic [31:0] v);
		return (v == VAL_FORBID) ? VAL_MIN : v;
	endfunction

	function automatic logic [31:0] sat33(input logic signed [32:0] v);
		logic [31:0] r;
		r = v[31:0];
		if (v > 33'(VAL_MAX)) begin
			r = VAL_MAX;
		end else if (v < 33'(VAL_MIN)) begin
			r = VAL_MIN;
		end
		return r;
	endfunction

	// flag bit of limit slot i: tests 2, 3, then 5..12
	function automatic int lim_test_num(input int i);
		return (i < 2) ? i + 2 : i + 3;
	endfunction

	// register state
	lbe_ctrl_t ctrl_reg;
	lbe_pats_t pats_reg;
	logic [31:0] null_reg;
	logic [31:0] lower_reg [NLIM];
	logic [31:0] upper_reg [NLIM];
	lbe_lim_pats_t lpats_reg [NLIM];
	logic [FAIL_W-1:0] fail_reg;
	logic [31:0] latest_reg;
	logic have_rd_reg;
	logic acq_pend_reg;
	logic binned_reg;
	logic [3:0] bin_pat_reg;
	logic pend_any_reg;
	logic pend_fail_reg;
	logic [3:0] pend_pat_reg;
	logic [3:0] dout_reg;

	// bus state
	logic aw_held_reg;
	logic w_held_reg;
	logic [7:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic awready_reg;
	logic wready_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic arready_reg;
	logic rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;

	// write channel decode
	wire aw_take = s_axi_awvalid & awready_reg;
	wire w_take = s_axi_wvalid & wready_reg;
	wire wr_fire = aw_held_reg & w_held_reg & ~bvalid_reg;
	wire aw_held_next = (aw_held_reg | aw_take) & ~wr_fire;
	wire w_held_next = (w_held_reg | w_take) & ~wr_fire;
	wire bvalid_next = wr_fire | (bvalid_reg & ~s_axi_bready);
	wire [7:0] wr_lim_off = awaddr_reg - OFS_LIM_BASE;
	wire [3:0] wr_lim_idx = wr_lim_off[7:4];
	wire [1:0] wr_lim_sub = wr_lim_off[3:2];
	wire wr_lim_hit = (awaddr_reg >= OFS_LIM_BASE) && (awaddr_reg < OFS_LIM_END) && (wr_lim_sub != 2'h3);
	wire wr_ctrl = wr_fire && (awaddr_reg == OFS_CTRL);
	wire wr_cmd = wr_fire && (awaddr_reg == OFS_CMD);
	wire wr_null = wr_fire && (awaddr_reg == OFS_NULL);
	wire wr_pats = wr_fire && (awaddr_reg == OFS_PATS);
	wire wr_known = wr_lim_hit || (awaddr_reg == OFS_CTRL) || (awaddr_reg == OFS_CMD) ||
		(awaddr_reg == OFS_NULL) || (awaddr_reg == OFS_PATS) || (awaddr_reg == OFS_FAIL) ||
		(awaddr_reg == OFS_LATEST) || (awaddr_reg == OFS_STAT);
	wire cmd_acq = wr_cmd & wstrb_reg[0] & wdata_reg[CMD_ACQ];
	wire cmd_clr = wr_cmd & wstrb_reg[0] & wdata_reg[CMD_CLR];

	// read channel decode
	wire ar_take = s_axi_arvalid & arready_reg;
	wire rvalid_next = (rvalid_reg & ~s_axi_rready) | ar_take;
	wire [7:0] rd_lim_off = s_axi_araddr - OFS_LIM_BASE;
	wire [3:0] rd_lim_idx = rd_lim_off[7:4];
	wire [1:0] rd_lim_sub = rd_lim_off[3:2];
	wire rd_lim_hit = (s_axi_araddr >= OFS_LIM_BASE) && (s_axi_araddr < OFS_LIM_END) && (rd_lim_sub != 2'h3);

	// feed selection and null offset; 33 bits so the difference cannot wrap
	wire signed [31:0] feed_sel = (ctrl_reg.feed == FEED_MATH) ? reading.math :
		(ctrl_reg.feed == FEED_VOLT) ? reading.volt :
		(ctrl_reg.feed == FEED_CURR) ? reading.curr : reading.res;
	wire signed [32:0] feed_ext = 33'(feed_sel);
	wire signed [32:0] null_ext = ctrl_reg.null_en ? 33'($signed(null_reg)) : 33'sh0;
	wire signed [32:0] test_val = feed_ext - null_ext;

	// enables: a disabled test produces neither pass nor fail
	wire any_limx_en = |ctrl_reg.limx_en;
	wire any_en = any_limx_en | ctrl_reg.lim1_en | ctrl_reg.contact_en;
	wire ct_fail = ctrl_reg.contact_en & contact_fail;
	wire compl_fail = ctrl_reg.lim1_en & (ctrl_reg.compl_fail_out ? ~in_compliance : in_compliance);

	// per-band inclusive compares
	logic [NLIM-1:0] lo_fail;
	logic [NLIM-1:0] up_fail;
	logic [NLIM-1:0] band_pass;
	genvar gi;
	generate
		for (gi = 0; gi < NLIM; gi++) begin : g_band
			assign lo_fail[gi] = ctrl_reg.limx_en[gi] & (test_val < 33'($signed(lower_reg[gi])));
			assign up_fail[gi] = ctrl_reg.limx_en[gi] & (test_val > 33'($signed(upper_reg[gi])));
			assign band_pass[gi] = ctrl_reg.limx_en[gi] & ~lo_fail[gi] & ~up_fail[gi];
		end
	endgenerate

	// pattern choice; loops run from the back so the earliest test wins
	logic [3:0] grade_pat;
	logic grade_fail;
	logic [3:0] sort_pat;
	logic [3:0] raw_pat;
	logic eval_fail;
	logic [FAIL_W-1:0] fail_set;
	always_comb begin
		grade_pat = pats_reg.composite_pass_pat;
		grade_fail = 1'b0;
		sort_pat = pats_reg.composite_fail_pat;
		fail_set = '0;
		for (int i = NLIM - 1; i >= 0; i--) begin
			if (up_fail[i]) begin
				grade_pat = lpats_reg[i].upper_pat;
				grade_fail = 1'b1;
			end
			if (lo_fail[i]) begin
				grade_pat = lpats_reg[i].lower_pat; // lower checked before upper
				grade_fail = 1'b1;
			end
			if (band_pass[i]) begin
				sort_pat = lpats_reg[i].pass_pat;
			end
			fail_set[lim_test_num(i)] = lo_fail[i] | up_fail[i];
		end
		if (!any_limx_en) begin
			sort_pat = pats_reg.composite_pass_pat;
		end
		// band fail patterns are not consulted while sorting
		raw_pat = ctrl_reg.sorting ? sort_pat : grade_pat;
		eval_fail = ctrl_reg.sorting ? (any_limx_en & ~|band_pass) : grade_fail;
		if (compl_fail) begin
			raw_pat = pats_reg.compl_fail_pat;
			eval_fail = 1'b1;
		end
		if (ct_fail) begin
			raw_pat = pats_reg.contact_fail_pat; // contact first
			eval_fail = 1'b1;
		end
		fail_set[FBIT_COMPL] = compl_fail;
		fail_set[FBIT_CONTACT] = ct_fail;
	end

	// line 4 of an evaluated pattern is forced low in 3-bit mode; the ordinary pattern is not masked
	wire [3:0] eval_pat = raw_pat & (ctrl_reg.four_bit ? PAT4_MASK : PAT3_MASK);
	wire eval_go = reading_valid & any_en;

	// write channel handshake
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			awaddr_reg <= 8'h00;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
		end else begin
			aw_held_reg <= aw_held_next;
			w_held_reg <= w_held_next;
			// ready stays low until the pending response is taken
			awready_reg <= ~aw_held_next & ~bvalid_next;
			wready_reg <= ~w_held_next & ~bvalid_next;
			if (aw_take) begin
				awaddr_reg <= s_axi_awaddr;
			end
			if (w_take) begin
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
		end
	end

	// write response, one per completed pair
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_reg <= 1'b1;
			bresp_reg <= wr_known ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	// read mux, unmapped reads return zero with an error response
	logic [31:0] rd_word;
	logic rd_ok;
	always_comb begin
		rd_word = 32'h0000_0000;
		rd_ok = 1'b1;
		if (rd_lim_hit) begin
			unique case (rd_lim_sub)
				LSUB_LOWER: rd_word = lower_reg[rd_lim_idx];
				LSUB_UPPER: rd_word = upper_reg[rd_lim_idx];
				default: rd_word = 32'(lpats_reg[rd_lim_idx]);
			endcase
		end else begin
			unique case (s_axi_araddr)
				OFS_CTRL: rd_word = 32'(ctrl_reg);
				OFS_CMD: rd_word = 32'h0000_0000;
				OFS_NULL: rd_word = null_reg;
				OFS_PATS: rd_word = 32'(pats_reg);
				OFS_FAIL: rd_word = 32'(fail_reg);
				OFS_LATEST: rd_word = any_en ? latest_reg : 32'h0000_0000;
				OFS_STAT: rd_word = 32'({acq_pend_reg, have_rd_reg, binned_reg, dout_reg});
				default: rd_ok = 1'b0;
			endcase
		end
	end

	// read channel; reading has no side effect on the flags
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= RESP_OKAY;
		end else begin
			arready_reg <= ~rvalid_next;
			rvalid_reg <= rvalid_next;
			if (ar_take) begin
				rdata_reg <= rd_word;
				rresp_reg <= rd_ok ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	// configuration registers
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			ctrl_reg <= CTRL_RST;
			pats_reg <= PATS_RST;
		end else begin
			if (wr_ctrl) begin
				ctrl_reg <= lbe_ctrl_t'(merge_bytes(32'(ctrl_reg), wdata_reg, wstrb_reg));
			end
			if (wr_pats) begin
				pats_reg <= lbe_pats_t'(merge_bytes(32'(pats_reg), wdata_reg, wstrb_reg));
			end
		end
	end

	// band bounds and patterns
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			for (int i = 0; i < NLIM; i++) begin
				lower_reg[i] <= LOWER_DEF;
				upper_reg[i] <= UPPER_DEF;
				lpats_reg[i] <= LPATS_RST;
			end
		end else if (wr_fire && wr_lim_hit) begin
			unique case (wr_lim_sub)
				LSUB_LOWER: lower_reg[wr_lim_idx] <= clamp_val(merge_bytes(lower_reg[wr_lim_idx],
					wdata_reg, wstrb_reg));
				LSUB_UPPER: upper_reg[wr_lim_idx] <= clamp_val(merge_bytes(upper_reg[wr_lim_idx],
					wdata_reg, wstrb_reg));
				default: lpats_reg[wr_lim_idx] <= lbe_lim_pats_t'(merge_bytes(32'(lpats_reg[wr_lim_idx]),
					wdata_reg, wstrb_reg));
			endcase
		end
	end

	// null offset: software write, acquire now, or acquire on next reading
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			null_reg <= 32'h0000_0000;
			acq_pend_reg <= 1'b0;
			have_rd_reg <= 1'b0;
		end else begin
			if (reading_valid) begin
				have_rd_reg <= 1'b1;
			end
			if (cmd_acq && (have_rd_reg || reading_valid)) begin
				null_reg <= clamp_val(feed_sel);
				acq_pend_reg <= 1'b0;
			end else if (cmd_acq) begin
				acq_pend_reg <= 1'b1; // wait for the first reading
			end else if (acq_pend_reg && reading_valid) begin
				null_reg <= clamp_val(feed_sel);
				acq_pend_reg <= 1'b0;
			end else if (wr_null) begin
				null_reg <= clamp_val(merge_bytes(null_reg, wdata_reg, wstrb_reg));
			end
		end
	end

	// sticky result flags; a failure in the clear cycle survives
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			fail_reg <= '0;
			latest_reg <= 32'h0000_0000;
		end else begin
			fail_reg <= (cmd_clr ? '0 : fail_reg) | (eval_go ? fail_set : '0);
			if (eval_go) begin
				latest_reg <= sat33(test_val);
			end
		end
	end

	// binning: immediate update or held to sweep end
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			binned_reg <= 1'b0;
			bin_pat_reg <= 4'h0;
			pend_any_reg <= 1'b0;
			pend_fail_reg <= 1'b0;
			pend_pat_reg <= 4'h0;
		end else if (cmd_clr) begin
			// in immediate mode a reading binned in the clear cycle survives, as the flags do; in end mode the held result is dropped
			binned_reg <= eval_go & ~ctrl_reg.end_update;
			if (eval_go) begin
				bin_pat_reg <= eval_pat;
			end
			pend_any_reg <= 1'b0;
			pend_fail_reg <= 1'b0;
		end else if (!ctrl_reg.end_update) begin
			if (eval_go) begin
				bin_pat_reg <= eval_pat;
				binned_reg <= 1'b1;
			end
		end else begin
			// keep the package's first failure, otherwise its latest pass
			if (eval_go && !pend_fail_reg) begin
				pend_pat_reg <= eval_pat;
				pend_fail_reg <= eval_fail;
				pend_any_reg <= 1'b1;
			end
			if (sweep_done && pend_any_reg) begin
				bin_pat_reg <= pend_pat_reg;
				binned_reg <= 1'b1;
				pend_any_reg <= 1'b0;
				pend_fail_reg <= 1'b0;
			end
		end
	end

	// lines follow the outcome only while a test is enabled
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			dout_reg <= 4'h0;
		end else begin
			dout_reg <= (any_en && binned_reg) ? bin_pat_reg : pats_reg.ordinary_pat;
		end
	end

	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign dout_lines = dout_reg;

endmodule

// ---- bench/lbe_limit_stage_properties.sv ----
// bus and output-line properties of the limit-test binning engine
`timescale 1ns/10ps

module lbe_limit_stage_properties
	import lbe_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic reading_valid,
	input wire logic sweep_done,
	input wire logic [3:0] dout_lines
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);

	// cycles since anything that may move the lines; saturates so it never wraps
	logic [2:0] quiet_cnt;
	wire logic cause = reading_valid | sweep_done | (s_axi_awvalid & s_axi_awready);
	always_ff @(posedge sys_clk) begin
		if (!rstn || cause) begin
			quiet_cnt <= 3'h0;
		end else if (quiet_cnt != 3'h7) begin
			quiet_cnt <= quiet_cnt + 3'h1;
		end
	end

	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped before bready");
	read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held until rready");
	wr_latency_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:2] s_axi_bvalid) else $error("write response late");
	rd_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	reset_clear_a: assert property (disable iff (1'b0) !rstn |=> dout_lines == 4'h0 && !s_axi_bvalid
		&& !s_axi_rvalid) else $error("outputs not cleared by reset");
	lines_cause_a: assert property ($changed(dout_lines) |-> quiet_cnt <= 3'h4)
		else $error("output lines moved without a cause");
	aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("new write accepted while response pending");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("new read accepted while data pending");
	resp_code_a: assert property (s_axi_rvalid |-> s_axi_rresp == RESP_OKAY || s_axi_rresp == RESP_SLVERR)
		else $error("illegal read response code");
endmodule

bind lbe_limit_stage lbe_limit_stage_properties lbe_limit_stage_properties_inst (.sys_clk, .rstn,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
	.reading_valid, .sweep_done, .dout_lines);

// ---- bench/lbe_handler_model.sv ----
// part handler: latches the output lines when told to look
`timescale 1ns/10ps

module lbe_handler_model (
	input wire logic sys_clk,
	input wire logic [3:0] dout_lines,
	input wire logic look_req,
	output logic [3:0] seen_lines,
	output logic seen_valid
);
	// a real handler only reads the lines when it is asked to bin
	always_ff @(posedge sys_clk) begin
		seen_valid <= look_req;
		if (look_req) begin
			seen_lines <= dout_lines;
		end
	end
endmodule

// ---- bench/lbe_limit_stage_tb.sv ----
// self-checking bench of the limit-test binning engine
`timescale 1ns/10ps

module lbe_limit_stage_tb
	import lbe_pkg::*;
;
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	lbe_reading_t reading = '0;
	logic reading_valid = 1'b0, in_compliance = 1'b0, contact_fail = 1'b0, sweep_done = 1'b0;
	logic [3:0] dout_lines, seen_lines;
	logic look_req = 1'b0;
	logic seen_valid;
	logic [33:0] exp_q[$];
	string name_q[$];
	int err_count = 0;
	int check_count = 0;
	logic [31:0] seed = 32'h0000_7AF2;

	always #2.5 sys_clk = ~sys_clk;

	lbe_limit_stage lbe_limit_stage_inst (.sys_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .reading, .reading_valid, .in_compliance, .contact_fail, .sweep_done, .dout_lines);
	lbe_handler_model lbe_handler_model_inst (.sys_clk, .dout_lines, .look_req, .seen_lines, .seen_valid);

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// expected bin: contact, compliance, then band 0 [-1,1] and band 1 [0,5], lower first
	function automatic logic [3:0] exp_pat(int v, logic cf, logic ic, logic [31:0] c);
		logic [3:0] p;
		if (cf) p = 4'h2;
		else if (ic ^ c[6]) p = 4'h1;
		else if (!c[3]) p = v < -1 ? 4'h6 : v > 1 ? 4'hF : v < 0 ? 4'hE : v > 5 ? 4'h4 : 4'hB;
		else p = (v >= -1 && v <= 1) ? 4'h9 : (v >= 0 && v <= 5) ? 4'hA : 4'hC;
		return c[4] ? p : p & 4'h7;
	endfunction

	task automatic tally_and_finish();
		if (err_count == 0 && check_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [33:0] v);
		check_count++;
		if (exp_q.size() == 0) begin
			err_count++;
			$display("mismatch unexpected result expected none seen %h", v);
		end else begin
			if (exp_q[0] !== v) begin
				err_count++;
				$display("mismatch %s expected %h seen %h", name_q[0], exp_q[0], v);
			end
			void'(exp_q.pop_front());
			void'(name_q.pop_front());
		end
	endtask

	// monitor: every result takes the oldest note
	always @(posedge sys_clk) begin
		if (s_axi_bvalid === 1'b1 && s_axi_bready) chk({s_axi_bresp, 32'h0});
		if (s_axi_rvalid === 1'b1 && s_axi_rready) chk({s_axi_rresp, s_axi_rdata});
		if (seen_valid === 1'b1) chk({30'h0, seen_lines});
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		logic aw_done, w_done;
		exp_q.push_back({r, 32'h0});
		name_q.push_back("write response");
		aw_done = 1'b0;
		w_done = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hF;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge sys_clk);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_done = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_done = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		s_axi_bready <= 1'b1;
		do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		exp_q.push_back(e);
		name_q.push_back($sformatf("register %h", a));
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b1;
		do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
	endtask

	// lines settle two cycles after their cause, then the handler looks
	task automatic look(input logic [3:0] e);
		exp_q.push_back({30'h0, e});
		name_q.push_back("output lines");
		repeat (2) @(posedge sys_clk);
		look_req <= 1'b1;
		@(posedge sys_clk);
		look_req <= 1'b0;
	endtask

	task automatic give(input logic [127:0] r, input logic cf, input logic ic);
		reading <= r;
		contact_fail <= cf;
		in_compliance <= ic;
		reading_valid <= 1'b1;
		@(posedge sys_clk);
		reading_valid <= 1'b0;
	endtask

	initial begin
		int v;
		logic cf, ic;
		logic [31:0] c;
		logic [31:0] fv [4];
		repeat (10) @(posedge sys_clk);
		rstn <= 1'b1;
		@(posedge sys_clk);
		rd(OFS_CTRL, 34'h0);
		rd(OFS_LIM_BASE, {2'h0, LOWER_DEF});
		rd(8'h44, {2'h0, UPPER_DEF});
		rd(OFS_FAIL, 34'h0);
		rd(8'h4C, {RESP_SLVERR, 32'h0});
		wr(8'hFC, 32'h1, RESP_SLVERR);
		wr(OFS_PATS, 32'h0005_CB21, RESP_OKAY);
		wr(OFS_NULL, 32'h1, RESP_OKAY);
		wr(8'h48, 32'h0000_09F6, RESP_OKAY);
		wr(8'h50, 32'h8000_0000, RESP_OKAY);
		rd(8'h50, {2'h0, 32'h8000_0001});
		wr(8'h50, 32'h0, RESP_OKAY);
		wr(8'h54, 32'h5, RESP_OKAY);
		wr(8'h58, 32'h0000_0A4E, RESP_OKAY);
		look(4'h5);
		// random feed, null, mode, width and compliance polarity
		for (int i = 0; i < 48; i++) begin
			c = 32'h0000_0780 | (rnd() & 32'h0000_005F);
			v = int'(rnd() % 11) - 3;
			foreach (fv[k]) fv[k] = rnd();
			fv[c[1:0]] = v;
			cf = (rnd() % 8) == 0;
			ic = rnd() % 2;
			wr(OFS_CTRL, c, RESP_OKAY);
			give({fv[0], fv[1], fv[2], fv[3]}, cf, ic);
			v = v - (c[2] ? 1 : 0);
			look(exp_pat(v, cf, ic, c));
			rd(OFS_LATEST, {2'h0, 32'(v)});
		end
		wr(OFS_CMD, 32'h1, RESP_OKAY);
		rd(OFS_NULL, {2'h0, fv[c[1:0]]});
		wr(OFS_CMD, 32'h2, RESP_OKAY);
		rd(OFS_FAIL, 34'h0);
		look(4'h5);
		wr(OFS_CTRL, 32'h0000_0781, RESP_OKAY);
		give({32'h0, 32'h3, 64'h0}, 1'b0, 1'b0);
		look(4'h7);
		rd(OFS_FAIL, 34'h4);
		rd(OFS_FAIL, 34'h4);
		// end mode holds the bin until the package is done
		wr(OFS_CMD, 32'h2, RESP_OKAY);
		wr(OFS_CTRL, 32'h0000_07A1, RESP_OKAY);
		give({32'h0, 32'hFFFF_FFFD, 64'h0}, 1'b0, 1'b0);
		give({32'h0, 32'h3, 64'h0}, 1'b0, 1'b0);
		look(4'h5);
		sweep_done <= 1'b1;
		@(posedge sys_clk);
		sweep_done <= 1'b0;
		look(4'h6);
		wr(OFS_CTRL, 32'h0, RESP_OKAY);
		look(4'h5);
		rd(OFS_LATEST, 34'h0);
		repeat (4) @(posedge sys_clk);
		err_count += exp_q.size();
		tally_and_finish();
	end

	// watchdog well beyond the expected run of about 550 cycles
	initial begin
		repeat (8000) @(posedge sys_clk);
		err_count++;
		tally_and_finish();
	end
endmodule
